// file: hdl/asc_chain_ctrl.sv
/*
 * Active serial chain loader, top level. Loads its own image from a
 * serial memory, then enables the next device and, in concurrent mode, also
 * streams a second copy to identical slaves, and handles the shared fault and done lines.
 * Assumes open-drain pins are resolved outside with pull-ups, and that
 * the link clock is a free-running oscillator.
 */
`timescale 1ns/1ps
module asc_chain_ctrl
  import asc_pkg::*;
(
  input wire logic i_clk,               // System clock, 25 MHz.
  input wire logic i_srst,              // Synchronous reset, high.
  input wire logic i_link_clk,          // Oscillator clock of the link.
  input wire logic i_reload_n,          // Reload request pin, low active.
  input wire logic [3:0] i_scheme_select, // Scheme select strap pins.
  input wire logic i_auto_restart,      // Restart by itself after error.
  input wire logic i_concurrent,        // Stream a second copy to slaves.
  input wire logic i_chain_enable_in_n, // Chain enable pin, low active.
  input wire logic i_serial_data,       // Data pin from the memory.
  input wire logic i_done_line,         // Level on shared done line.
  input wire logic i_fault_line,        // Level on shared fault line.
  output logic o_done_o,                // Done line drive value, zero.
  output logic o_done_oe,               // Done line pulled low.
  output logic o_fault_o,               // Fault line drive value, zero.
  output logic o_fault_oe,              // Fault line pulled low.
  output logic o_chain_enable_out_n,    // Chain enable out, low active.
  output logic o_memory_select_out_n,   // Memory select, low active.
  output logic o_serial_load_clock,     // Serial load clock pin.
  output logic o_init_start,            // One-cycle start of init.
  output logic o_user_mode              // Device has entered user mode.
);

  // Bounds for the assertions below.
  localparam int REL_MAX = 3;

  typedef enum logic [2:0] {
    ST_RESET, ST_OWN, ST_COPY, ST_WAIT, ST_USER, ST_ERROR, ST_SLAVE
  } state_t;

  asc_link_if lk (); // Carrier to the link-side shifter.

  logic [1:0] rel_s, done_s, flt_s;   // Pin synchronisers.
  logic [3:0] sch_s0, sch_s1;         // Scheme select synchroniser.
  logic [2:0] own_s, copy_s, err_s;   // Toggle sync plus edge stage.
  logic own_ev, copy_ev, err_ev;      // One-cycle link events.
  logic reload_hi;                    // Reload request released.
  logic master;                       // Strapped to load actively.
  state_t st_q, st_d;                 // Controller state.
  logic go_q, go_d;                   // Link run request.
  logic chain_q, chain_d;             // Chain enable out, low active.
  logic init_q, init_d;               // Initialization start pulse.
  logic [11:0] tmo_q, tmo_d;          // Restart time-out counter.

  // Link side, in the oscillator domain.
  asc_link u_link (
    .i_link_clk(i_link_clk),
    .i_srst(i_srst),
    .i_chain_enable_in_n(i_chain_enable_in_n),
    .i_serial_data(i_serial_data),
    .lk(lk.link),
    .o_serial_load_clock(o_serial_load_clock),
    .o_memory_select_out_n(o_memory_select_out_n)
  );

  // Pin and toggle synchronisers; the first stage feeds only the second.
  always_ff @(posedge i_clk) begin
    rel_s <= {rel_s[0], i_reload_n};
    done_s <= {done_s[0], i_done_line};
    flt_s <= {flt_s[0], i_fault_line};
    sch_s0 <= i_scheme_select;
    sch_s1 <= sch_s0;
    own_s <= {own_s[1:0], lk.own_tgl};
    copy_s <= {copy_s[1:0], lk.copy_tgl};
    err_s <= {err_s[1:0], lk.err_tgl};
  end

  // Edge of each toggle turns it back into a single-cycle event.
  always_comb begin
    own_ev = own_s[1] ^ own_s[2];
    copy_ev = copy_s[1] ^ copy_s[2];
    err_ev = err_s[1] ^ err_s[2];
    reload_hi = rel_s[1];
    master = (sch_s1 != SCHEME_PASSIVE);
  end

  // Controller next state. A low reload overrides everything else.
  always_comb begin
    st_d = st_q;
    go_d = go_q;
    chain_d = chain_q;
    init_d = 1'b0;
    tmo_d = '0;
    if (!reload_hi) begin
      st_d = ST_RESET;
      go_d = 1'b0;
      chain_d = 1'b1;
    end else begin
      unique case (st_q)
        ST_RESET: begin
          // Leaving reset also releases the fault line.
          st_d = master ? ST_OWN : ST_SLAVE;
          go_d = master;
        end
        ST_OWN: begin
          chain_d = 1'b1;
          if (err_ev) begin
            st_d = ST_ERROR;
            go_d = 1'b0;
          end else if (own_ev) begin
            // Both modes enable downstream; concurrent mode also
            // keeps streaming the second copy to the slaves.
            chain_d = 1'b0;
            st_d = i_concurrent ? ST_COPY : ST_WAIT;
          end
        end
        ST_COPY: begin
          if (copy_ev) begin
            st_d = ST_WAIT;
            go_d = 1'b0;
          end
        end
        ST_WAIT: begin
          // The line only reads high once every device let go of it.
          if (done_s[1]) begin
            st_d = ST_USER;
            init_d = 1'b1;
            go_d = 1'b0;
          end
        end
        ST_USER: begin
          st_d = ST_USER;
        end
        ST_ERROR: begin
          // Without auto restart only a reload pulse gets out of here.
          if (i_auto_restart) begin
            tmo_d = tmo_q + 1'b1;
            if (tmo_q == RESTART_CYC - 12'h001) begin
              st_d = ST_OWN;
              go_d = 1'b1;
            end
          end
        end
        ST_SLAVE: begin
          st_d = ST_SLAVE;
        end
      endcase
    end
  end

  // Controller registers.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q <= ST_RESET;
      go_q <= 1'b0;
      chain_q <= CHAIN_OUT_N_RST;
      init_q <= 1'b0;
      tmo_q <= '0;
    end else begin
      st_q <= st_d;
      go_q <= go_d;
      chain_q <= chain_d;
      init_q <= init_d;
      tmo_q <= tmo_d;
    end
  end

  // Open-drain drives: fault during reset and error, done until loaded.
  // Done is also held in the slave state: this block has no passive
  // loader, so it must never let the chain initialise early.
  always_comb begin
    o_fault_oe = (st_q == ST_RESET) || (st_q == ST_ERROR);
    o_done_oe = (st_q != ST_WAIT) && (st_q != ST_USER);
    o_fault_o = 1'b0;
    o_done_o = 1'b0;
  end

  assign lk.go = go_q;
  assign o_chain_enable_out_n = chain_q;
  assign o_init_start = init_q;
  assign o_user_mode = (st_q == ST_USER);

  a_reset_holds: assert property (@(posedge i_clk)
    disable iff (i_srst) !reload_hi |=> (o_fault_oe && !go_q))
    else $error("device not held in reset while reload is low");

  a_fault_release: assert property (@(posedge i_clk)
    disable iff (i_srst) ($rose(reload_hi) && master)
      |-> ##[1:REL_MAX] (!o_fault_oe || !reload_hi))
    else $error("fault line not released after reload rose");

  a_chain_enable: assert property (@(posedge i_clk)
    disable iff (i_srst) (st_q == ST_OWN && own_ev && !err_ev && reload_hi)
      |=> (!o_chain_enable_out_n && (st_q == ST_COPY || !o_done_oe)))
    else $error("chain not enabled after own image");

  a_done_held: assert property (@(posedge i_clk)
    disable iff (i_srst) (st_q == ST_OWN || st_q == ST_COPY) |-> o_done_oe)
    else $error("done line released before load complete");

  a_init_start: assert property (@(posedge i_clk)
    disable iff (i_srst) (st_q == ST_WAIT && done_s[1] && reload_hi)
      |=> (o_init_start ##1 (!o_init_start && o_user_mode)))
    else $error("initialization did not start on done high");

  a_error_fault: assert property (@(posedge i_clk)
    disable iff (i_srst) (st_q == ST_OWN && err_ev && reload_hi)
      |=> (o_fault_oe && !go_q))
    else $error("error did not drive the fault line");

  a_restart_due: assert property (@(posedge i_clk)
    disable iff (i_srst) (st_q == ST_ERROR && i_auto_restart && reload_hi
      && tmo_q == RESTART_CYC - 12'h001) |=> (st_q == ST_OWN && go_q))
    else $error("automatic restart not taken on time-out");

  a_conc_hold: assert property (@(posedge i_clk)
    disable iff (i_srst) (st_q == ST_OWN) |-> o_chain_enable_out_n)
    else $error("chain enabled during own load");

  a_copy_stream: assert property (@(posedge i_clk)
    disable iff (i_srst) (st_q == ST_COPY) |-> (!o_chain_enable_out_n
      && go_q && o_done_oe))
    else $error("second copy not streamed with chain enabled");

  c_user_mode: cover property (@(posedge i_clk) disable iff (i_srst)
    $rose(o_user_mode));
  c_copy_done: cover property (@(posedge i_clk) disable iff (i_srst)
    st_q == ST_COPY ##1 st_q == ST_WAIT);
  c_auto_restart: cover property (@(posedge i_clk) disable iff (i_srst)
    st_q == ST_ERROR ##1 st_q == ST_OWN);
  c_fault_seen: cover property (@(posedge i_clk) disable iff (i_srst)
    !flt_s[1] && st_q == ST_OWN);

endmodule : asc_chain_ctrl

// file: hdl/asc_pkg.sv
/*
 * Shared constants for the active serial chain loader: pin codes,
 * reset values, image geometry and cycle counts.
 * Assumes a 25 MHz system clock and a free-running oscillator link clock.
 */
package asc_pkg;

  // System clock rate in MHz.
  localparam int CLK_MHZ = 25;

  // Longest reset time-out before an automatic restart, in microseconds.
  localparam int T_RESTART_US = 100;
  // Cycles for that time-out; a longest time rounds down.
  localparam logic [11:0] RESTART_CYC = 12'(T_RESTART_US * CLK_MHZ);

  // Longest time from reload release to fault release, in microseconds.
  localparam int T_FAULT_REL_US = 100;
  // Cycles for that bound, rounded down.
  localparam int FAULT_REL_CYC = T_FAULT_REL_US * CLK_MHZ;

  // Scheme select code of a passive slave; any other code loads actively.
  localparam logic [3:0] SCHEME_PASSIVE = 4'h2;

  // Width of the link bit counter.
  localparam int CNT_W = 12;
  // Bits in one stored image copy.
  localparam logic [11:0] IMAGE_BITS = 12'h400;
  // End of the second copy; the counter saturates here.
  localparam logic [11:0] COPY_END = 12'h800;
  // Leading bits of an image that must match the sync pattern.
  localparam logic [11:0] SYNC_BITS = 12'h008;
  // Sync pattern at the head of every image; a plain default.
  localparam logic [7:0] SYNC_WORD = 8'h6A;

  // Reset values of the pins this block drives.
  localparam logic CHAIN_OUT_N_RST = 1'b1;
  localparam logic MEM_SEL_N_RST = 1'b1;
  localparam logic LOAD_CLK_RST = 1'b1;

endpackage : asc_pkg

// file: hdl/asc_link_if.sv
/*
 * Carrier between the controller and its link-side shifter.
 * Assumes each side synchronises what it receives: go is a level,
 * the three events are toggles.
 */
`timescale 1ns/1ps
interface asc_link_if;
  logic go;       // Controller wants the serial link running.
  logic own_tgl;  // Toggles when the own image is complete.
  logic copy_tgl; // Toggles when the second copy has been streamed.
  logic err_tgl;  // Toggles when an image head fails the sync check.

  modport ctrl (output go, input own_tgl, input copy_tgl, input err_tgl);
  modport link (input go, output own_tgl, output copy_tgl, output err_tgl);
endinterface : asc_link_if

// file: hdl/asc_link.sv
/*
 * Link-side shifter: runs on the oscillator clock, makes the serial
 * load clock by halving it, selects the memory and counts bits in.
 * Assumes the controller holds go low long enough for a restart to be
 * seen here (it does: the restart time-out is thousands of cycles).
 */
`timescale 1ns/1ps
module asc_link
  import asc_pkg::*;
(
  input wire logic i_link_clk,          // Oscillator clock of the link.
  input wire logic i_srst,              // System reset, other domain.
  input wire logic i_chain_enable_in_n, // Chain enable pin, low active.
  input wire logic i_serial_data,       // Data pin from the memory.
  asc_link_if.link lk,                  // Carrier to the controller.
  output logic o_serial_load_clock,     // Serial load clock pin.
  output logic o_memory_select_out_n    // Memory select pin, low active.
);

  logic [1:0] rst_s, go_s, ce_s, dat_s; // Two-stage synchronisers.
  logic lclk_q, lclk_d;                 // Divided serial clock.
  logic sel_n_q, sel_n_d;               // Memory select, low active.
  logic lead_q, lead_d;                 // Memory selected a cycle ago.
  logic [CNT_W-1:0] cnt_q, cnt_d;       // Bits taken in this load.
  logic [7:0] sh_q, sh_d;               // Head of the image.
  logic own_q, own_d, copy_q, copy_d, err_q, err_d; // Event toggles.
  logic run;                            // Link may clock this cycle.
  logic fall;                           // Serial clock falls now.
  logic take;                           // Bit under the last fall is in.

  // Synchronisers: stage 0 is read only by stage 1.
  always_ff @(posedge i_link_clk) begin
    rst_s <= {rst_s[0], i_srst};
    go_s <= {go_s[0], lk.go};
    ce_s <= {ce_s[0], i_chain_enable_in_n};
    dat_s <= {dat_s[0], i_serial_data};
  end

  // Next-state logic of the shifter.
  always_comb begin
    run = go_s[1] & ~ce_s[1];
    // The clock waits until the memory has been selected for two link
    // cycles, so the synchronised pin already shows the first bit.
    lead_d = run & ~sel_n_q;
    fall = run & lead_q & lclk_q;
    // A bit is taken one link cycle after its fall: the synchroniser
    // then shows what the pin held when the clock fell.
    take = run & ~lclk_q;
    lclk_d = ~fall;
    // The memory stays selected for the whole load; a dropped go
    // deselects it, which also resets the memory on a restart.
    sel_n_d = ~run;
    cnt_d = cnt_q;
    sh_d = sh_q;
    own_d = own_q;
    copy_d = copy_q;
    err_d = err_q;
    if (!go_s[1]) begin
      cnt_d = '0;
      sh_d = '0;
    end else if (take && cnt_q != COPY_END) begin
      // Exactly one bit per serial clock, as it stood at its fall.
      cnt_d = cnt_q + 1'b1;
      sh_d = {sh_q[6:0], dat_s[1]};
      if (cnt_d == SYNC_BITS && sh_d != SYNC_WORD) begin
        err_d = ~err_q;
      end
      if (cnt_d == IMAGE_BITS) begin
        own_d = ~own_q;
      end
      if (cnt_d == COPY_END) begin
        copy_d = ~copy_q;
      end
    end
  end

  // Registers of the shifter; reset arrives through the synchroniser.
  always_ff @(posedge i_link_clk) begin
    if (rst_s[1]) begin
      lclk_q <= LOAD_CLK_RST;
      sel_n_q <= MEM_SEL_N_RST;
      lead_q <= 1'b0;
      cnt_q <= '0;
      sh_q <= '0;
      own_q <= 1'b0;
      copy_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      lclk_q <= lclk_d;
      sel_n_q <= sel_n_d;
      lead_q <= lead_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      own_q <= own_d;
      copy_q <= copy_d;
      err_q <= err_d;
    end
  end

  assign o_serial_load_clock = lclk_q;
  assign o_memory_select_out_n = sel_n_q;
  assign lk.own_tgl = own_q;
  assign lk.copy_tgl = copy_q;
  assign lk.err_tgl = err_q;

  a_bit_per_clock: assert property (@(posedge i_link_clk)
    disable iff (rst_s[1]) (go_s[1] && !take) |=> $stable(cnt_q))
    else $error("bit counted without a falling serial clock");

  a_denied_idle: assert property (@(posedge i_link_clk)
    disable iff (rst_s[1]) ce_s[1] |=> (lclk_q && sel_n_q))
    else $error("link active while chain enable is inactive");

endmodule : asc_link

// file: testbench/asc_mem_model.sv
/*
 * Behavioural serial memory: hands out two image copies, one bit per
 * falling load clock while selected.
 * Assumes a pull-up on the data pin while the memory is not selected.
 */
`timescale 1ns/1ps
module asc_mem_model
  import asc_pkg::*;
(
  input wire logic i_load_clk, // Load clock from the loader.
  input wire logic i_sel_n,    // Memory select, low active.
  input wire logic i_corrupt,  // Spoil the head of the first copy.
  output logic o_data          // Data pin towards the loader.
);
  logic [11:0] idx_q; // Bits handed out since select.
  logic [9:0] pos;    // Position inside one copy.
  logic img_bit;      // Bit of the image at that position.

  initial idx_q = 12'h000;
  // A new bit per falling load clock; deselect restarts the image.
  always @(negedge i_load_clk or posedge i_sel_n) begin
    if (i_sel_n) begin
      idx_q <= 12'h000;
    end else begin
      idx_q <= idx_q + 12'h001;
    end
  end

  // Head word, then a filler that changes every bit.
  always_comb begin
    pos = idx_q[9:0];
    if (pos < 10'h008) begin
      img_bit = SYNC_WORD[3'h7 - pos[2:0]] ^ (i_corrupt & ~idx_q[10]);
    end else begin
      img_bit = pos[0];
    end
  end
  // Released pin floats up to the pull-up level.
  assign o_data = i_sel_n ? 1'b1 : img_bit;
endmodule : asc_mem_model

// file: testbench/test_asc_chain_ctrl.sv
/*
 * Self-checking bench for the chain loader: cascade and concurrent
 * loads, errors with and without restart, reload and chain blocking.
 * Assumes pull-ups on done and fault lines, resolved here.
 */
`timescale 1ns/1ps
module test_asc_chain_ctrl;
  import asc_pkg::*;
  logic clk, srst, link_clk, reload_n, auto_rs, conc, cein_n;
  logic corrupt, slave_hold, data, done_oe, fault_oe, chain_n;
  logic sel_n, sclk, init_start, user_mode;
  logic done_o, fault_o;
  logic [3:0] scheme;
  int fails, num_checks, falls, n;
  typedef struct { logic conc; logic done_oe; } row_t;
  row_t rows [2] = '{'{1'b0, 1'b0}, '{1'b1, 1'b1}};

  asc_chain_ctrl dut (.i_clk(clk), .i_srst(srst), .i_link_clk(link_clk),
    .i_reload_n(reload_n), .i_scheme_select(scheme),
    .i_auto_restart(auto_rs), .i_concurrent(conc),
    .i_chain_enable_in_n(cein_n), .i_serial_data(data),
    .i_done_line(!done_oe && !slave_hold), .i_fault_line(!fault_oe),
    .o_done_o(done_o), .o_done_oe(done_oe), .o_fault_o(fault_o),
    .o_fault_oe(fault_oe),
    .o_chain_enable_out_n(chain_n), .o_memory_select_out_n(sel_n),
    .o_serial_load_clock(sclk), .o_init_start(init_start),
    .o_user_mode(user_mode));
  asc_mem_model mem (.i_load_clk(sclk), .i_sel_n(sel_n),
    .i_corrupt(corrupt), .o_data(data));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // The oscillator runs free, out of phase with the system clock.
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  // Bits clocked while the memory is selected.
  always @(negedge sclk) if (sel_n === 1'b0) falls = falls + 1;

  task automatic give_verdict();
    if (fails == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask : check

  // Inputs move two nanoseconds after the rising edge.
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : tick

  function automatic logic pick(input int w);
    case (w)
      0: pick = chain_n;
      1: pick = fault_oe;
      2: pick = init_start;
      default: pick = done_oe;
    endcase
  endfunction : pick

  // Bounded wait; running out ends the run as a failure.
  task automatic wait_on(input int w, input logic v, input int lim);
    n = 0;
    while (pick(w) !== v && n < lim) begin
      tick(1);
      n++;
    end
    if (n >= lim) begin
      fails++;
      $display("BAD wait %0d expected %0h seen timeout", w, v);
      give_verdict();
    end
  endtask : wait_on

  // Full reset with reload low, then reload released.
  task automatic start(input logic c, a, e, ce);
    conc = c; auto_rs = a; corrupt = e; cein_n = ce; slave_hold = 1'b1;
    srst = 1'b1;
    reload_n = 1'b0;
    tick(16);
    srst = 1'b0;
    tick(2);
    check("rst_fault", 1, fault_oe);
    check("rst_done", 1, done_oe);
    check("rst_user", 0, user_mode);
    falls = 0;
    reload_n = 1'b1;
    wait_on(1, 1'b0, FAULT_REL_CYC);
    check("chain_own", 1, chain_n);
    check("od_zero", 0, {done_o, fault_o});
  endtask : start

  initial begin
    fails = 0; num_checks = 0; falls = 0; srst = 1'b1; reload_n = 1'b0;
    auto_rs = 1'b0; conc = 1'b0; cein_n = 1'b0; corrupt = 1'b0;
    slave_hold = 1'b1;
    scheme = 4'hD;
    // Cascade and concurrent loads, one row each.
    for (int r = 0; r < 2; r++) begin
      start(rows[r].conc, 1'b0, 1'b0, 1'b0);
      wait_on(0, 1'b0, 2000);
      check("done_at_chain", rows[r].done_oe, done_oe);
      check("own_bits", 1, falls >= 1024 && falls <= 1044);
      check("sel_load", 0, sel_n);
      if (rows[r].conc) begin
        wait_on(3, 1'b0, 2000);
        check("copy_bits", 1, falls >= 2048 && falls <= 2068);
        check("chain_copy", 0, chain_n);
      end
      tick(20);
      check("held_user", 0, user_mode);
      slave_hold = 1'b0;
      wait_on(2, 1'b1, 8);
      tick(1);
      check("init_pulse", 0, init_start);
      check("user_on", 1, user_mode);
    end
    // Reload from user mode puts the device back in reset.
    reload_n = 1'b0;
    tick(4);
    check("rl_user", 0, user_mode);
    check("rl_fault", 1, fault_oe);
    // Head error with restart enabled.
    start(1'b0, 1'b1, 1'b1, 1'b0);
    wait_on(1, 1'b1, 500);
    check("err_chain", 1, chain_n);
    tick(4);
    check("err_sel", 1, sel_n);
    corrupt = 1'b0;
    wait_on(1, 1'b0, 2600);
    check("restart_cyc", 1, n <= 32'(RESTART_CYC) + 2);
    wait_on(0, 1'b0, 2000);
    // Head error without restart: only a reload pulse recovers.
    start(1'b0, 1'b0, 1'b1, 1'b0);
    wait_on(1, 1'b1, 500);
    tick(2700);
    check("err_stays", 1, fault_oe);
    reload_n = 1'b0;
    corrupt = 1'b0;
    tick(10);
    check("rl_sel", 1, sel_n);
    reload_n = 1'b1;
    wait_on(1, 1'b0, FAULT_REL_CYC);
    wait_on(0, 1'b0, 2000);
    // Chain enable input high keeps the link shut.
    start(1'b0, 1'b0, 1'b0, 1'b1);
    tick(100);
    check("blk_sel", 1, sel_n);
    check("blk_bits", 0, falls);
    cein_n = 1'b0;
    wait_on(0, 1'b0, 2000);
    // Passive strap: the block idles, holds done and keeps the link shut.
    scheme = SCHEME_PASSIVE;
    start(1'b0, 1'b0, 1'b0, 1'b0);
    tick(100);
    check("pas_sel", 1, sel_n);
    check("pas_bits", 0, falls);
    check("pas_done", 1, done_oe);
    check("pas_user", 0, user_mode);
    give_verdict();
  end
endmodule : test_asc_chain_ctrl
